//--- core/cltd_pkg.sv
// Constants and types shared by the channel level trigger detector.
package cltd_pkg;
  // Register byte addresses.
  localparam logic [15:0] CLTD_GLOBAL_SRC_OFS  = 16'h9c40;
  localparam logic [15:0] CLTD_CH0_COND_OFS    = 16'h9d08;
  localparam logic [15:0] CLTD_CH0_UPPER_OFS   = 16'ha410;
  localparam logic [15:0] CLTD_CH0_LOWER_OFS   = 16'ha474;
  localparam logic [15:0] CLTD_PULSE_WIDTH_OFS = 16'habe0;
  localparam logic [15:0] CLTD_STATUS_OFS      = 16'hac00;

  // Mode codes for the global source select and the channel condition.
  localparam logic [31:0] CLTD_PER_CHANNEL_DETECTION = 32'h00004e48;
  localparam logic [31:0] CLTD_RISING_EDGE_MODE      = 32'h00002710;
  localparam logic [31:0] CLTD_FALLING_EDGE_MODE     = 32'h0000271a;
  localparam logic [31:0] CLTD_DUAL_EDGE_MODE        = 32'h0000272e;
  localparam logic [31:0] CLTD_LONG_HIGH_PULSE_MODE  = 32'h00002711;
  localparam logic [31:0] CLTD_LONG_LOW_PULSE_MODE   = 32'h0000271b;
  localparam logic [31:0] CLTD_SHORT_HIGH_PULSE_MODE = 32'h00002712;
  localparam logic [31:0] CLTD_SHORT_LOW_PULSE_MODE  = 32'h0000271c;
  localparam logic [31:0] CLTD_FLAT_RISE_MODE        = 32'h00002713;

  // Values after reset.
  localparam logic [31:0] CLTD_SRC_RST   = 32'h00000000;
  localparam logic [31:0] CLTD_COND_RST  = 32'h00000000;
  localparam logic [31:0] CLTD_LEVEL_RST = 32'h00000000;
  localparam logic [7:0]  CLTD_WIDTH_RST = 8'h02;

  // Status register field positions.
  localparam int unsigned CLTD_ST_BUSY_BIT  = 0;
  localparam int unsigned CLTD_ST_PREV_BIT  = 1;
  localparam int unsigned CLTD_ST_CNT_LSB   = 8;
  localparam int unsigned CLTD_ST_TRIGS_LSB = 16;

  // Decoded channel condition.
  typedef enum logic [3:0] {
    CLTD_K_OFF,
    CLTD_K_RISE,
    CLTD_K_FALL,
    CLTD_K_DUAL,
    CLTD_K_LONG_POS,
    CLTD_K_LONG_NEG,
    CLTD_K_SHORT_POS,
    CLTD_K_SHORT_NEG,
    CLTD_K_FLAT
  } cltd_kind_t;

  // Pulse measurement state.
  typedef enum logic {
    CLTD_IDLE,
    CLTD_COUNT
  } cltd_state_t;
endpackage

//--- core/cltd_xing_if.sv
// Bundle between the detector and one level crossing comparator.
`timescale 1ns/1ns
interface cltd_xing_if #(
  parameter int unsigned LW = 6
);
  logic signed [LW-1:0] prev;
  logic signed [LW-1:0] cur;
  logic signed [LW-1:0] level;
  logic                 rise;
  logic                 fall;
  modport cmp  (input prev, input cur, input level, output rise, output fall);
  modport user (output prev, output cur, output level, input rise, input fall);
endinterface

//--- core/cltd_level_cmp.sv
// Crossing comparator of one level against two successive samples.
`timescale 1ns/1ns
module cltd_level_cmp (
  cltd_xing_if.cmp x  // Sample pair, level and crossing flags.
);
  // A crossing needs the old sample strictly on one side and the new one at
  // or past the level, so a signal resting on the level fires only once.
  assign x.rise = (x.prev < x.level) && (x.cur >= x.level);
  assign x.fall = (x.prev > x.level) && (x.cur <= x.level);
endmodule

//--- core/cltd_detector.sv
// Channel level trigger detector with its register file.
`timescale 1ns/1ns
// Operation
// - Evaluate every valid sample in turn, none skipped.
// - Per-channel rising-edge mode triggers on an upward level crossing.
// - Falling-edge mode triggers on a downward level crossing.
// - Dual-edge mode triggers on any crossing of the level.
// - Long pulse counter starts on rising (high) or falling (low) crossing.
// - Long pulse: opposite crossing before width aborts without trigger.
// - Long pulse: counter reaching width triggers.
// - Short pulse counter starts on a crossing; reaching width ends quietly.
// - Short pulse: crossing back before width triggers.
// - Flat rise mode starts counting on upward lower-level crossing.
// - Flat rise: upper-level crossing before width abandons without trigger.
// - Flat rise: counter reaching width triggers.
// - Compare only sample top bits; levels symmetric, most negative unused.
module cltd_detector
  import cltd_pkg::*;
#(
  parameter int unsigned SAMPLE_W = 8,  // Converter sample width.
  parameter int unsigned LEVEL_W  = 6,  // Compared top bits and level width.
  parameter int unsigned PW_W     = 8   // Pulse width counter width.
) (
  input  wire logic                sys_clk,       // System clock, 250 MHz.
  input  wire logic                sys_rst,       // Synchronous reset, high.
  input  wire logic [15:0]         reg_addr,      // Register byte address.
  input  wire logic [31:0]         reg_wdata,     // Register write data.
  input  wire logic                reg_wr,        // Write strobe.
  input  wire logic                reg_rd,        // Read strobe.
  output logic      [31:0]         reg_rdata,     // Read data, next cycle.
  input  wire logic                sample_valid,  // One converted sample.
  input  wire logic [SAMPLE_W-1:0] sample_data,   // Signed sample value.
  output logic                     trig_event     // Trigger pulse.
);
  import cltd_pkg::*;

  logic [31:0]          global_src;
  logic [31:0]          cond;
  logic [31:0]          upper;
  logic [31:0]          lower;
  logic [PW_W-1:0]      width;
  logic signed [LEVEL_W-1:0] prev_msb;
  logic signed [LEVEL_W-1:0] cur_msb;
  logic                 have_prev;
  cltd_state_t          state;
  cltd_state_t          next_state;
  logic [PW_W-1:0]      cnt;
  logic [PW_W-1:0]      next_cnt;
  logic                 next_trig;
  logic [15:0]          trig_count;
  cltd_kind_t           kind;
  logic                 active;
  logic                 up_rise;
  logic                 up_fall;
  logic                 lo_rise;
  logic                 start_x;
  logic                 opp_x;
  logic                 edge_hit;
  logic                 reach;
  logic                 cfg_wr;

  // Maps a condition code onto the internal kind; unknown codes disable.
  function automatic cltd_kind_t cltd_decode(input logic [31:0] code);
    cltd_kind_t k;
    k = CLTD_K_OFF;
    if (code == CLTD_RISING_EDGE_MODE) begin
      k = CLTD_K_RISE;
    end else if (code == CLTD_FALLING_EDGE_MODE) begin
      k = CLTD_K_FALL;
    end else if (code == CLTD_DUAL_EDGE_MODE) begin
      k = CLTD_K_DUAL;
    end else if (code == CLTD_LONG_HIGH_PULSE_MODE) begin
      k = CLTD_K_LONG_POS;
    end else if (code == CLTD_LONG_LOW_PULSE_MODE) begin
      k = CLTD_K_LONG_NEG;
    end else if (code == CLTD_SHORT_HIGH_PULSE_MODE) begin
      k = CLTD_K_SHORT_POS;
    end else if (code == CLTD_SHORT_LOW_PULSE_MODE) begin
      k = CLTD_K_SHORT_NEG;
    end else if (code == CLTD_FLAT_RISE_MODE) begin
      k = CLTD_K_FLAT;
    end
    return k;
  endfunction

  // Register writes; the level registers keep the full word for readback.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      global_src <= CLTD_SRC_RST;
      cond       <= CLTD_COND_RST;
      upper      <= CLTD_LEVEL_RST;
      lower      <= CLTD_LEVEL_RST;
      width      <= CLTD_WIDTH_RST;
    end else if (reg_wr) begin
      if (reg_addr == CLTD_GLOBAL_SRC_OFS) begin
        global_src <= reg_wdata;
      end else if (reg_addr == CLTD_CH0_COND_OFS) begin
        cond <= reg_wdata;
      end else if (reg_addr == CLTD_CH0_UPPER_OFS) begin
        upper <= reg_wdata;
      end else if (reg_addr == CLTD_CH0_LOWER_OFS) begin
        lower <= reg_wdata;
      end else if (reg_addr == CLTD_PULSE_WIDTH_OFS) begin
        width <= reg_wdata[PW_W-1:0];
      end
    end
  end

  // Read data stand for one cycle only; unmapped addresses read zero.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      if (reg_addr == CLTD_GLOBAL_SRC_OFS) begin
        reg_rdata <= global_src;
      end else if (reg_addr == CLTD_CH0_COND_OFS) begin
        reg_rdata <= cond;
      end else if (reg_addr == CLTD_CH0_UPPER_OFS) begin
        reg_rdata <= upper;
      end else if (reg_addr == CLTD_CH0_LOWER_OFS) begin
        reg_rdata <= lower;
      end else if (reg_addr == CLTD_PULSE_WIDTH_OFS) begin
        reg_rdata <= {{(32-PW_W){1'b0}}, width};
      end else if (reg_addr == CLTD_STATUS_OFS) begin
        reg_rdata <= {trig_count, cnt, 6'h00, have_prev, state == CLTD_COUNT};
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // Any write to the mode or width restarts a running measurement.
  assign cfg_wr = reg_wr && ((reg_addr == CLTD_GLOBAL_SRC_OFS) ||
                  (reg_addr == CLTD_CH0_COND_OFS) ||
                  (reg_addr == CLTD_PULSE_WIDTH_OFS));

  // Only the top bits take part; the most negative code never matches a
  // level because levels stop at minus the largest positive value.
  assign cur_msb = sample_data[SAMPLE_W-1 -: LEVEL_W];

  // Previous sample kept on every valid sample so no crossing is missed.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prev_msb  <= '0;
      have_prev <= 1'b0;
    end else if (sample_valid) begin
      prev_msb  <= cur_msb;
      have_prev <= 1'b1;
    end
  end

  cltd_xing_if #(.LW(LEVEL_W)) up_x ();
  cltd_xing_if #(.LW(LEVEL_W)) lo_x ();

  assign up_x.prev  = prev_msb;
  assign up_x.cur   = cur_msb;
  assign up_x.level = upper[LEVEL_W-1:0];
  assign lo_x.prev  = prev_msb;
  assign lo_x.cur   = cur_msb;
  assign lo_x.level = lower[LEVEL_W-1:0];

  cltd_level_cmp u_up_cmp (
    .x (up_x)
  );

  cltd_level_cmp u_lo_cmp (
    .x (lo_x)
  );

  // Crossings count only on a real sample with a real predecessor.
  assign up_rise = sample_valid && have_prev && up_x.rise;
  assign up_fall = sample_valid && have_prev && up_x.fall;
  assign lo_rise = sample_valid && have_prev && lo_x.rise;

  assign kind   = cltd_decode(cond);
  assign active = (global_src == CLTD_PER_CHANNEL_DETECTION);
  // Widths below two are not meant to be used; a compare with >= keeps
  // such values from locking the counter.
  assign reach  = ({1'b0, cnt} + {{PW_W{1'b0}}, 1'b1}) >= {1'b0, width};

  // Start and opposite crossings for the pulse and steepness modes.
  always_comb begin
    start_x  = 1'b0;
    opp_x    = 1'b0;
    edge_hit = 1'b0;
    case (kind)
      CLTD_K_RISE: begin
        edge_hit = up_rise;
      end
      CLTD_K_FALL: begin
        edge_hit = up_fall;
      end
      CLTD_K_DUAL: begin
        edge_hit = up_rise || up_fall;
      end
      CLTD_K_LONG_POS, CLTD_K_SHORT_POS: begin
        start_x = up_rise;
        opp_x   = up_fall;
      end
      CLTD_K_LONG_NEG, CLTD_K_SHORT_NEG: begin
        start_x = up_fall;
        opp_x   = up_rise;
      end
      CLTD_K_FLAT: begin
        start_x = lo_rise;
        opp_x   = up_rise;
      end
      default: begin
        start_x = 1'b0;
      end
    endcase
  end

  // Measurement sequencing; a crossing in the final sample outranks reach.
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_trig  = 1'b0;
    if (!active || cfg_wr || kind == CLTD_K_OFF || kind == CLTD_K_RISE ||
        kind == CLTD_K_FALL || kind == CLTD_K_DUAL) begin
      next_state = CLTD_IDLE;
      next_cnt   = '0;
      next_trig  = active && edge_hit;
    end else if (sample_valid) begin
      case (state)
        CLTD_IDLE: begin
          if (start_x) begin
            next_state = CLTD_COUNT;
            next_cnt   = '0;
          end
        end
        CLTD_COUNT: begin
          if (opp_x) begin
            next_state = CLTD_IDLE;
            next_cnt   = '0;
            // Short pulse fires here; long and flat drop out silently.
            next_trig  = (kind == CLTD_K_SHORT_POS) ||
                         (kind == CLTD_K_SHORT_NEG);
          end else if (reach) begin
            next_state = CLTD_IDLE;
            next_cnt   = '0;
            next_trig  = (kind == CLTD_K_LONG_POS) || (kind == CLTD_K_LONG_NEG) ||
                         (kind == CLTD_K_FLAT);
          end else begin
            next_cnt = cnt + {{(PW_W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          next_state = CLTD_IDLE;
        end
      endcase
    end
  end

  // Measurement state.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= CLTD_IDLE;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Trigger pulse, one cycle after the deciding sample.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      trig_event <= 1'b0;
    end else begin
      trig_event <= next_trig;
    end
  end

  // Trigger tally for status; it wraps rather than saturates.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      trig_count <= 16'h0000;
    end else if (next_trig) begin
      trig_count <= trig_count + 16'h0001;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  chk_sample_kept: assert property (
    sample_valid |=> (prev_msb == $past(cur_msb)) && have_prev)
    else $error("previous sample not captured");

  chk_msb_compare: assert property (
    up_rise |-> ($signed(prev_msb) < $signed(upper[LEVEL_W-1:0])) &&
                ($signed(sample_data[SAMPLE_W-1 -: LEVEL_W]) >=
                 $signed(upper[LEVEL_W-1:0])))
    else $error("rising crossing without top bits crossing level");

  chk_rise_edge: assert property (
    active && !cfg_wr && kind == CLTD_K_RISE && up_rise |=> trig_event)
    else $error("rising edge missed");

  chk_fall_edge: assert property (
    active && !cfg_wr && kind == CLTD_K_FALL |=> trig_event == $past(up_fall))
    else $error("falling edge trigger wrong");

  chk_dual_edge: assert property (
    active && !cfg_wr && kind == CLTD_K_DUAL && (up_rise || up_fall) |=> trig_event)
    else $error("dual edge crossing missed");

  chk_long_start: assert property (
    active && !cfg_wr && kind == CLTD_K_LONG_NEG && state == CLTD_IDLE && up_fall
    |=> state == CLTD_COUNT && cnt == '0)
    else $error("long low pulse did not start");

  chk_long_abort: assert property (
    active && !cfg_wr && kind == CLTD_K_LONG_POS && state == CLTD_COUNT && up_fall
    |=> !trig_event && state == CLTD_IDLE)
    else $error("long pulse abort failed");

  chk_long_fire: assert property (
    active && !cfg_wr && kind == CLTD_K_LONG_POS && state == CLTD_COUNT &&
    sample_valid && !up_fall && reach |=> trig_event && cnt == '0)
    else $error("long pulse trigger missed");

  chk_short_expire: assert property (
    active && !cfg_wr && kind == CLTD_K_SHORT_POS && state == CLTD_COUNT &&
    sample_valid && !up_fall && reach |=> !trig_event && state == CLTD_IDLE)
    else $error("short pulse expiry raised trigger");

  chk_short_fire: assert property (
    active && !cfg_wr && kind == CLTD_K_SHORT_NEG && state == CLTD_COUNT && up_rise
    |=> trig_event ##1 !trig_event)
    else $error("short pulse trigger wrong");

  chk_flat_start: assert property (
    active && !cfg_wr && kind == CLTD_K_FLAT && state == CLTD_IDLE && lo_rise
    |=> state == CLTD_COUNT)
    else $error("flat rise did not start");

  chk_flat_abort: assert property (
    active && !cfg_wr && kind == CLTD_K_FLAT && state == CLTD_COUNT && up_rise
    |=> !trig_event && state == CLTD_IDLE)
    else $error("flat rise abandon failed");

  chk_flat_fire: assert property (
    active && !cfg_wr && kind == CLTD_K_FLAT && state == CLTD_COUNT &&
    sample_valid && !up_rise && reach |=> trig_event)
    else $error("flat rise trigger missed");

  chk_rearm_clear: assert property (
    state == CLTD_COUNT ##1 state == CLTD_IDLE |-> cnt == '0)
    else $error("counter not cleared on re-arm");

  cov_long_fire: cover property (
    kind == CLTD_K_LONG_POS && state == CLTD_COUNT ##1 trig_event);
  cov_short_fire: cover property (
    kind == CLTD_K_SHORT_POS && state == CLTD_COUNT ##1 trig_event);
  cov_flat_fire: cover property (
    kind == CLTD_K_FLAT && state == CLTD_COUNT ##1 trig_event);
  cov_dual_edge: cover property (
    kind == CLTD_K_DUAL && up_fall ##1 trig_event);
endmodule

//--- testbench/cltd_sample_src.sv
// Behavioural model of the converter sample stream that feeds the detector.
`timescale 1ns/1ns
module cltd_sample_src (
  input  wire logic       sys_clk,       // Sample clock, shared with the system.
  input  wire logic       slow,          // High to leave a gap after each sample.
  output logic            sample_valid,  // One sample on the lines.
  output logic      [7:0] sample_data    // Two's complement sample.
);
  logic [7:0] pend[$];
  logic       gap;
  logic [7:0] last;

  task automatic push(input logic [7:0] v);
    pend.push_back(v);
  endtask

  function automatic int depth();
    return pend.size();
  endfunction

  initial begin
    sample_valid = 1'b0;
    sample_data  = 8'h00;
    gap          = 1'b0;
    last         = 8'h00;
  end

  // Between samples the lines show the inverse of the last value, so a stale copy never passes.
  always @(posedge sys_clk) begin
    if (pend.size() != 0 && !(slow && gap)) begin
      last = pend.pop_front();
      sample_valid <= 1'b1;
      sample_data  <= last;
      gap          <= 1'b1;
    end else begin
      sample_valid <= 1'b0;
      sample_data  <= ~last;
      gap          <= 1'b0;
    end
  end
endmodule

//--- testbench/channel_level_trigger_detector_tb_top.sv
// Self-checking bench for the channel level trigger detector.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin check_count++; if (!((got) === (ex))) begin err_total++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module channel_level_trigger_detector_tb_top;
  import cltd_pkg::*;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        reg_wr;
  logic        reg_rd;
  logic        sample_valid;
  logic [7:0]  sample_data;
  logic        trig_event;
  logic        slow;
  logic        prev_valid;
  int          err_total;
  int          check_count;
  int          trig_seen;

  // A 4 ns period gives the 250 MHz system clock.
  always #2 sys_clk = ~sys_clk;

  cltd_detector uut (
    .sys_clk      (sys_clk),
    .sys_rst      (sys_rst),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata    (reg_rdata),
    .sample_valid (sample_valid),
    .sample_data  (sample_data),
    .trig_event   (trig_event)
  );

  cltd_sample_src src (
    .sys_clk      (sys_clk),
    .slow         (slow),
    .sample_valid (sample_valid),
    .sample_data  (sample_data)
  );

  // Counts trigger pulses; each must follow an accepted sample by exactly one cycle.
  // Sampling on the falling edge sees the pulse settled, away from the edge that launches it.
  always @(negedge sys_clk) begin
    if (trig_event === 1'b1) begin
      trig_seen++;
      `CHK("trig_after_sample", 1'b1, prev_valid)
    end
    prev_valid <= sample_valid;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, then drops to zero.
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] ex, input string nm);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(nm, ex, reg_rdata)
    @(posedge sys_clk);
    #1;
    `CHK("rdata_idle", 32'h0, reg_rdata)
  endtask

  task automatic cfg(input logic [31:0] c, input int up, input int lo, input int w);
    wr(CLTD_GLOBAL_SRC_OFS, CLTD_PER_CHANNEL_DETECTION);
    wr(CLTD_CH0_UPPER_OFS, 32'(up));
    wr(CLTD_CH0_LOWER_OFS, 32'(lo));
    wr(CLTD_PULSE_WIDTH_OFS, 32'(w));
    wr(CLTD_CH0_COND_OFS, c);
  endtask

  // Values are top-bit codes; the two low bits are set so only the top bits may matter.
  task automatic feed(input int v[$], input int ex, input string nm);
    int base;
    int n;
    #1;
    base = trig_seen;
    foreach (v[i]) src.push({v[i][5:0], 2'b11});
    n = 0;
    while (src.depth() != 0 && n < 500) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 500) begin
      err_total++;
      complete_run();
    end
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK(nm, ex, trig_seen - base)
  endtask

  task automatic t_regs();
    rd_chk(CLTD_GLOBAL_SRC_OFS, CLTD_SRC_RST, "src_rst");
    rd_chk(CLTD_CH0_COND_OFS, CLTD_COND_RST, "cond_rst");
    rd_chk(CLTD_CH0_UPPER_OFS, CLTD_LEVEL_RST, "upper_rst");
    rd_chk(CLTD_CH0_LOWER_OFS, CLTD_LEVEL_RST, "lower_rst");
    rd_chk(CLTD_PULSE_WIDTH_OFS, {24'h0, CLTD_WIDTH_RST}, "width_rst");
    wr(CLTD_CH0_UPPER_OFS, 32'h0000001f);
    rd_chk(CLTD_CH0_UPPER_OFS, 32'h0000001f, "upper_rw");
    wr(CLTD_CH0_LOWER_OFS, 32'hffffffe1);
    rd_chk(CLTD_CH0_LOWER_OFS, 32'hffffffe1, "lower_rw");
    wr(CLTD_PULSE_WIDTH_OFS, 32'h000001ff);
    rd_chk(CLTD_PULSE_WIDTH_OFS, 32'h000000ff, "width_rw");
    wr(16'h1234, 32'hffffffff);
    rd_chk(16'h1234, 32'h0, "unmapped");
  endtask

  // Two rises and one fall, with samples landing exactly on the level.
  task automatic t_edges();
    cfg(CLTD_RISING_EDGE_MODE, 4, 0, 3);
    feed('{-2, 4, -2, 4, 6, -2}, 2, "rise");
    cfg(CLTD_FALLING_EDGE_MODE, 4, 0, 3);
    feed('{-2, 4, -2, 4, 6, -2}, 1, "fall");
    cfg(CLTD_DUAL_EDGE_MODE, 4, 0, 3);
    feed('{-2, 4, -2, 4, 6, -2}, 3, "dual");
    wr(CLTD_GLOBAL_SRC_OFS, 32'h0);
    feed('{-2, 4, -2, 4, 6, -2}, 0, "src_off");
    // An unknown condition code must leave the channel silent.
    cfg(32'h00000000, 4, 0, 3);
    feed('{-2, 4, -2, 4, 6, -2}, 0, "cond_off");
  endtask

  // Width 3: a measurement left open across a pause must still fire on its third sample.
  task automatic t_long();
    cfg(CLTD_LONG_HIGH_PULSE_MODE, 4, 0, 3);
    feed('{-2, 6, 6, 6}, 0, "lh_wait");
    // Mid-measurement status: six triggers so far, two samples counted, busy.
    rd_chk(CLTD_STATUS_OFS, (32'd6 << CLTD_ST_TRIGS_LSB) | (32'd2 << CLTD_ST_CNT_LSB) |
           (32'd1 << CLTD_ST_PREV_BIT) | (32'd1 << CLTD_ST_BUSY_BIT), "status_busy");
    feed('{6, -2}, 1, "lh_fire");
    feed('{6, 6, -2}, 0, "lh_abort");
    cfg(CLTD_LONG_LOW_PULSE_MODE, 4, 0, 3);
    feed('{10, 2, 2, 2}, 0, "ll_wait");
    feed('{2, 10}, 1, "ll_fire");
    feed('{2, 2, 10}, 0, "ll_abort");
  endtask

  task automatic t_short();
    cfg(CLTD_SHORT_HIGH_PULSE_MODE, 4, 0, 3);
    feed('{-2, 6, 6, 6, 6, -2}, 0, "sh_expire");
    feed('{-2, 6, 6, 6, -2}, 1, "sh_fire");
    cfg(CLTD_SHORT_LOW_PULSE_MODE, 4, 0, 3);
    feed('{10, 2, 2, 2, 2, 10}, 0, "sl_expire");
    feed('{10, 2, 2, 2, 10}, 1, "sl_fire");
  endtask

  task automatic t_flat();
    cfg(CLTD_FLAT_RISE_MODE, 8, 0, 3);
    feed('{-4, 2, 2, 2}, 0, "fl_wait");
    feed('{2, 10}, 1, "fl_fire");
    feed('{-4, 2, 10, -4}, 0, "fl_abandon");
  endtask

  // The stream pauses after every sample; the outcome must not change.
  task automatic t_gaps();
    slow <= 1'b1;
    cfg(CLTD_LONG_HIGH_PULSE_MODE, 4, 0, 3);
    feed('{-2, 6, 6, 6, 6, -2}, 1, "gaps");
    slow <= 1'b0;
    // Twelve triggers in all, counter cleared and idle, a previous sample held.
    rd_chk(CLTD_STATUS_OFS, (32'd12 << CLTD_ST_TRIGS_LSB) | (32'd1 << CLTD_ST_PREV_BIT),
           "status_idle");
  endtask

  // Reset for 20 cycles, then run every scenario in turn.
  initial begin
    reg_addr    = 16'h0000;
    reg_wdata   = 32'h0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    slow        = 1'b0;
    prev_valid  = 1'b0;
    err_total   = 0;
    check_count = 0;
    trig_seen   = 0;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_edges();
    t_long();
    t_short();
    t_flat();
    t_gaps();
    complete_run();
  end
endmodule
